// file: trap_consts.vh
// constants for the trap vector, delegation and interrupt unit
`ifndef TRAP_CONSTS_VH
`define TRAP_CONSTS_VH
// control-register addresses, machine level
`define ADDR_TVEC 12'h305
`define ADDR_EDELEG 12'h302
`define ADDR_IDELEG 12'h303
`define ADDR_IE 12'h304
`define ADDR_IP 12'h344
// restricted views, hypervisor / supervisor / user
`define ADDR_H_IE 12'h204
`define ADDR_H_IP 12'h244
`define ADDR_S_IE 12'h104
`define ADDR_S_IP 12'h144
`define ADDR_U_IE 12'h004
`define ADDR_U_IP 12'h044
// privilege levels
`define PRV_U 2'h0
`define PRV_S 2'h1
`define PRV_H 2'h2
`define PRV_M 2'h3
// interrupt field layout: soft 0..3, timer 4..7, external 8..11
`define IRQ_BITS 12
`define SOFT_LSB 0
`define TIMER_LSB 4
`define EXT_LSB 8
`define M_SOFT_BIT 3
`define M_TIMER_BIT 7
// reset values and alignment
`define TVEC_RESET 32'h00000000
`define ALIGN_MASK 32'hFFFFFFFC
`define REG_RESET 32'h00000000
`define CAUSE_W 5
`endif

// file: deleg_target.v
// picks the mode that receives a trap whose delegation bit is set
`timescale 1ns/1ps
`default_nettype none
`include "trap_consts.vh"
module deleg_target #(
  parameter HAS_H = 1,
  parameter HAS_S = 1,
  parameter HAS_UTRAP = 0
) (
  output wire [1:0] o_level,
  output wire o_valid
);
  // highest lower mode wins; lower ones chain further on their own
  assign o_level = HAS_H ? `PRV_H : (HAS_S ? `PRV_S : `PRV_U);
  // without a lower trap handler nothing can be delegated
  assign o_valid = (HAS_H != 0) || (HAS_S != 0) || (HAS_UTRAP != 0);
endmodule
`default_nettype wire

// file: int_prio.v
// per-bit interrupt qualification and priority pick
`timescale 1ns/1ps
`default_nettype none
`include "trap_consts.vh"
module int_prio #(
  parameter N = 12
) (
  input wire [N-1:0] i_pend,
  input wire [N-1:0] i_en,
  input wire [N-1:0] i_deleg,
  input wire [1:0] i_priv,
  input wire [3:0] i_ie,
  input wire [1:0] i_dlvl,
  output reg o_take,
  output reg [3:0] o_idx,
  output reg [1:0] o_lvl
);
  wire [N-1:0] ok;
  wire [2*N-1:0] tgt;
  genvar g;
  // each bit: target mode, then global enable for that mode
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_bit
      wire [1:0] t;
      assign t = i_deleg[g] ? i_dlvl : `PRV_M;
      assign tgt[2*g+1:2*g] = t;
      // (RULE_20) pending, enabled, globally enabled
      // (RULE_21) delegated: target mode and its enable
      assign ok[g] = i_pend[g] && i_en[g] &&
        ((i_priv < t) || ((i_priv == t) && i_ie[t]));
    end
  endgenerate
  integer l;
  integer c;
  integer k;
  integer b;
  // higher target first; within one: external, software, timer
  always @* begin
    o_take = 1'b0;
    o_idx = 4'h0;
    o_lvl = `PRV_M;
    b = 0;
    for (l = 3; l >= 0; l = l - 1) begin
      for (c = 0; c < 3; c = c + 1) begin
        for (k = 3; k >= 0; k = k - 1) begin
          b = (c == 0) ? (8 + k) : ((c == 1) ? k : (4 + k));
          if (!o_take && ok[b] && (tgt[2*b+:2] == l[1:0])) begin
            o_take = 1'b1;
            o_idx = b[3:0];
            o_lvl = l[1:0];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: trap_ctrl.v
// trap vector, delegation and interrupt registers of one hart
`timescale 1ns/1ps
`default_nettype none
`include "trap_consts.vh"
// Summary of operation
// (RULE_01) vector base always word aligned on read
// (RULE_02) machine traps jump to vector base
// (RULE_03) three or two modes delegate to lower handler
// (RULE_04) four modes delegate to hypervisor handler
// (RULE_05) no lower handler: delegation registers zero
// (RULE_06) delegated trap writes target cause, pc, status
// (RULE_07) delegated trap leaves machine state untouched
// (RULE_08) unsupported delegation bits read back zero
// (RULE_09) exception delegation bit indexed by cause
// (RULE_10) interrupt delegation matches pending bit layout
// (RULE_11) only lower soft/timer pending bits writable
// (RULE_12) enable layout soft, timer, external nibbles
// (RULE_13) delegated interrupts show in lower views
// (RULE_14) machine timer pending follows compare level
// (RULE_15) machine can inject lower timer pending
// (RULE_16) lower soft pending writable at level or above
// (RULE_17) machine soft pending from mapped register only
// (RULE_18) external pending follows interrupt controller
// (RULE_19) unsupported level bits hardwired to zero
// (RULE_20) take when pending, enabled, globally enabled
// (RULE_21) delegated global enable uses target mode
// (RULE_22) external, software, timer, then synchronous
module trap_ctrl #(
  parameter HAS_H = 1,
  parameter HAS_S = 1,
  parameter HAS_UTRAP = 0,
  parameter TVEC_WRITABLE = 1,
  parameter [31:0] EXC_DELEG_MASK = 32'hFFFFFFFF
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_csr_re,
  input wire i_csr_we,
  input wire [11:0] i_csr_addr,
  input wire [31:0] i_csr_wdata,
  output reg o_csr_ack,
  output reg o_csr_illegal,
  output reg [31:0] o_csr_rdata,
  input wire [1:0] i_priv,
  input wire [3:0] i_ie,
  input wire [3:0] i_ext_pending,
  input wire i_machine_soft_pending,
  input wire i_machine_timer_pending,
  input wire i_boundary,
  input wire i_exc_valid,
  input wire [4:0] i_exc_cause,
  input wire [31:0] i_pc,
  input wire [31:0] i_deleg_tvec,
  output reg o_trap_valid,
  output reg o_trap_interrupt,
  output reg [4:0] o_trap_cause,
  output reg [1:0] o_trap_level,
  output reg [31:0] o_trap_epc,
  output reg [31:0] o_trap_pc,
  output reg [1:0] o_prior_priv,
  output reg o_prior_ie,
  output reg [3:0] o_cause_we,
  output reg [3:0] o_ie_clear,
  output wire o_irq_pending
);
  localparam NB = `IRQ_BITS;
  wire [1:0] dlvl;
  wire has_deleg;
  wire [3:0] lvl_ok;
  wire [NB-1:0] ie_mask;
  wire [NB-1:0] sw_mask;
  wire [NB-1:0] ideleg_mask;
  wire [31:0] edeleg_mask;
  reg [31:0] tvec_q;
  reg [31:0] edeleg_q;
  reg [NB-1:0] ideleg_q;
  reg [NB-1:0] ie_q;
  reg [NB-1:0] swp_q;
  wire [NB-1:0] ip_val;
  wire [NB-1:0] hw_pend;

  deleg_target #(
    .HAS_H(HAS_H),
    .HAS_S(HAS_S),
    .HAS_UTRAP(HAS_UTRAP)
  ) u_target (
    .o_level(dlvl),
    .o_valid(has_deleg)
  );

  // (RULE_19) unsupported levels
  // user-level interrupts only exist with user trap handling
  assign lvl_ok = {1'b1, HAS_H != 0, HAS_S != 0, HAS_UTRAP != 0};
  // (RULE_12) enable nibble layout
  assign ie_mask = {lvl_ok, lvl_ok, lvl_ok};
  // (RULE_11) writable pending subset
  assign sw_mask = {4'h0, 1'b0, lvl_ok[2:0], 1'b0, lvl_ok[2:0]};
  // (RULE_05) no lower handler
  // machine-level sources are never delegated here
  assign ideleg_mask = has_deleg ? {1'b0, lvl_ok[2:0], 1'b0,
    lvl_ok[2:0], 1'b0, lvl_ok[2:0]} : {NB{1'b0}};
  assign edeleg_mask = has_deleg ? EXC_DELEG_MASK : 32'h00000000;

  // (RULE_18) external levels
  // (RULE_17) soft level from mapped register
  // (RULE_14) timer level from compare
  assign hw_pend = {i_ext_pending & lvl_ok, i_machine_timer_pending,
    3'b000, i_machine_soft_pending, 3'b000};
  assign ip_val = hw_pend | (swp_q & sw_mask);

  // view selection: only the delegation target has a live view
  reg [1:0] a_lvl;
  reg view_live;
  reg [NB-1:0] view_mask;
  reg [NB-1:0] vsoft_mask;
  always @* begin
    a_lvl = i_csr_addr[9:8];
    view_live = has_deleg && (a_lvl == dlvl);
    // (RULE_13) delegated bits only
    view_mask = view_live ? ideleg_q : {NB{1'b0}};
    // (RULE_16) soft bits at or below view level
    case (a_lvl)
      `PRV_U: vsoft_mask = 12'h001;
      `PRV_S: vsoft_mask = 12'h003;
      `PRV_H: vsoft_mask = 12'h007;
      default: vsoft_mask = 12'h000;
    endcase
  end

  // address decode and read mux
  reg hit;
  reg [31:0] rd_d;
  reg we_tvec;
  reg we_edeleg;
  reg we_ideleg;
  reg we_ie;
  reg we_ip;
  reg we_vie;
  reg we_vip;
  wire access;
  wire priv_ok;
  assign access = i_csr_re || i_csr_we;
  // a register is reachable from its own level or above
  assign priv_ok = i_priv >= i_csr_addr[9:8];
  always @* begin
    hit = 1'b1;
    rd_d = 32'h00000000;
    we_tvec = 1'b0;
    we_edeleg = 1'b0;
    we_ideleg = 1'b0;
    we_ie = 1'b0;
    we_ip = 1'b0;
    we_vie = 1'b0;
    we_vip = 1'b0;
    case (i_csr_addr)
      `ADDR_TVEC: begin
        // (RULE_01) aligned readback
        rd_d = tvec_q & `ALIGN_MASK;
        we_tvec = 1'b1;
      end
      `ADDR_EDELEG: begin
        // (RULE_09) bit per cause
        rd_d = edeleg_q;
        we_edeleg = 1'b1;
      end
      `ADDR_IDELEG: begin
        // (RULE_10) pending layout
        rd_d = {20'h00000, ideleg_q};
        we_ideleg = 1'b1;
      end
      `ADDR_IE: begin
        rd_d = {20'h00000, ie_q};
        we_ie = 1'b1;
      end
      `ADDR_IP: begin
        rd_d = {20'h00000, ip_val};
        we_ip = 1'b1;
      end
      `ADDR_H_IE, `ADDR_S_IE, `ADDR_U_IE: begin
        rd_d = {20'h00000, ie_q & view_mask};
        we_vie = 1'b1;
      end
      `ADDR_H_IP, `ADDR_S_IP, `ADDR_U_IP: begin
        rd_d = {20'h00000, ip_val & view_mask};
        we_vip = 1'b1;
      end
      default: hit = 1'b0;
    endcase
  end

  wire wr;
  assign wr = i_csr_we && hit && priv_ok;

  // response is registered one cycle after the request
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_csr_ack <= 1'b0;
      o_csr_illegal <= 1'b0;
      o_csr_rdata <= 32'h00000000;
    end else begin
      o_csr_ack <= access;
      o_csr_illegal <= access && !(hit && priv_ok);
      o_csr_rdata <= (access && hit && priv_ok) ? rd_d : 32'h00000000;
    end
  end

  // vector base: low two bits are never stored as ones
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      tvec_q <= `TVEC_RESET;
    end else if (wr && we_tvec && (TVEC_WRITABLE != 0)) begin
      // (RULE_01) force alignment
      tvec_q <= i_csr_wdata & `ALIGN_MASK;
    end
  end

  // delegation registers; masks discover the supported subset
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      edeleg_q <= `REG_RESET;
      ideleg_q <= {NB{1'b0}};
    end else begin
      // (RULE_08) warl delegation bits
      if (wr && we_edeleg) begin
        edeleg_q <= i_csr_wdata & edeleg_mask;
      end
      if (wr && we_ideleg) begin
        ideleg_q <= i_csr_wdata[NB-1:0] & ideleg_mask;
      end
    end
  end

  // enable register, full and restricted view
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ie_q <= {NB{1'b0}};
    end else if (wr && we_ie) begin
      // (RULE_19) dead levels stay zero
      ie_q <= i_csr_wdata[NB-1:0] & ie_mask;
    end else if (wr && we_vie) begin
      // (RULE_13) view masks its own bits
      ie_q <= (ie_q & ~(view_mask & ie_mask)) |
        (i_csr_wdata[NB-1:0] & view_mask & ie_mask);
    end
  end

  // software-held pending bits; hardware never sets these,
  // so no set/clear race exists here
  reg [NB-1:0] vip_wmask;
  always @* begin
    vip_wmask = view_mask & vsoft_mask & sw_mask;
  end
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      swp_q <= {NB{1'b0}};
    end else if (wr && we_ip) begin
      // (RULE_15) timer injection
      // (RULE_11) other bits ignore writes
      swp_q <= i_csr_wdata[NB-1:0] & sw_mask;
    end else if (wr && we_vip) begin
      // (RULE_16) lower soft pending write
      swp_q <= (swp_q & ~vip_wmask) |
        (i_csr_wdata[NB-1:0] & vip_wmask);
    end
  end

  // interrupt selection
  wire irq_take;
  wire [3:0] irq_idx;
  wire [1:0] irq_lvl;
  int_prio #(
    .N(NB)
  ) u_prio (
    .i_pend(ip_val),
    .i_en(ie_q),
    .i_deleg(ideleg_q),
    .i_priv(i_priv),
    .i_ie(i_ie),
    .i_dlvl(dlvl),
    .o_take(irq_take),
    .o_idx(irq_idx),
    .o_lvl(irq_lvl)
  );
  // (RULE_20) qualified interrupt present
  assign o_irq_pending = irq_take;

  // (RULE_09) exception target by cause bit
  // (RULE_03) lower handler target
  // (RULE_04) hypervisor when present
  // a trap from above the target mode is never delegated
  wire exc_del;
  wire [1:0] exc_lvl;
  assign exc_del = edeleg_q[i_exc_cause] && (i_priv <= dlvl);
  assign exc_lvl = exc_del ? dlvl : `PRV_M;

  // (RULE_22) interrupts win over synchronous traps
  reg tk;
  reg tk_int;
  reg [1:0] tk_lvl;
  reg [4:0] tk_cause;
  always @* begin
    tk = 1'b0;
    tk_int = 1'b0;
    tk_lvl = `PRV_M;
    tk_cause = 5'h00;
    if (i_boundary && irq_take) begin
      tk = 1'b1;
      tk_int = 1'b1;
      tk_lvl = irq_lvl;
      tk_cause = {1'b0, irq_idx};
    end else if (i_exc_valid) begin
      tk = 1'b1;
      tk_lvl = exc_lvl;
      tk_cause = i_exc_cause;
    end
  end

  // trap report, one pulse per trap
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_trap_valid <= 1'b0;
      o_trap_interrupt <= 1'b0;
      o_trap_cause <= 5'h00;
      o_trap_level <= `PRV_M;
      o_trap_epc <= 32'h00000000;
      o_trap_pc <= 32'h00000000;
      o_prior_priv <= `PRV_U;
      o_prior_ie <= 1'b0;
      o_cause_we <= 4'h0;
      o_ie_clear <= 4'h0;
    end else begin
      o_trap_valid <= tk;
      if (tk) begin
        o_trap_interrupt <= tk_int;
        o_trap_cause <= tk_cause;
        o_trap_level <= tk_lvl;
        // (RULE_06) save pc, prior mode and enable
        o_trap_epc <= i_pc;
        o_prior_priv <= i_priv;
        o_prior_ie <= i_ie[i_priv];
        // (RULE_02) machine traps use the base
        o_trap_pc <= (tk_lvl == `PRV_M) ?
          (tvec_q & `ALIGN_MASK) : i_deleg_tvec;
      end
      // (RULE_07) one-hot: machine strobes only for machine
      // (RULE_06) target cause write, enable clear
      o_cause_we <= tk ? (4'h1 << tk_lvl) : 4'h0;
      o_ie_clear <= tk ? (4'h1 << tk_lvl) : 4'h0;
    end
  end

  // (RULE_21) delegated enable handled inside the selector
endmodule
`default_nettype wire

// file: trap_ctrl_sva.sv
// concurrent checks on the trap unit ports
`timescale 1ns/1ps
`default_nettype none
module trap_ctrl_sva (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_csr_re,
  input wire logic i_csr_we,
  input wire logic [11:0] i_csr_addr,
  input wire logic [31:0] i_csr_wdata,
  input wire logic [31:0] o_csr_rdata,
  input wire logic [1:0] i_priv,
  input wire logic [3:0] i_ie,
  input wire logic [3:0] i_ext_pending,
  input wire logic i_machine_soft_pending,
  input wire logic i_machine_timer_pending,
  input wire logic i_boundary,
  input wire logic i_exc_valid,
  input wire logic [4:0] i_exc_cause,
  input wire logic [31:0] i_deleg_tvec,
  input wire logic o_trap_valid,
  input wire logic o_trap_interrupt,
  input wire logic [4:0] o_trap_cause,
  input wire logic [1:0] o_trap_level,
  input wire logic [31:0] o_trap_pc,
  input wire logic [1:0] o_prior_priv,
  input wire logic o_prior_ie,
  input wire logic [3:0] o_cause_we,
  input wire logic [3:0] o_ie_clear,
  input wire logic o_irq_pending
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [31:0] tvec_q;
  // shadow of the vector base, machine writes only
  always @(posedge i_clk) begin
    if (i_sys_rst)
      tvec_q <= 32'h00000000;
    else if (i_csr_we && i_csr_addr == 12'h305 && i_priv == 2'h3)
      tvec_q <= i_csr_wdata & 32'hFFFFFFFC;
  end
  // machine read of one register, and any accepted trap
  sequence s_rd(a);
    i_csr_re && i_csr_addr == a && i_priv == 2'h3;
  endsequence
  sequence s_take;
    i_exc_valid || (i_boundary && o_irq_pending);
  endsequence
  AST_ALIGN: assert property (s_rd(12'h305) |=>
    o_csr_rdata == $past(tvec_q)) else $error("base read");
  AST_MVEC: assert property (o_trap_valid && o_trap_level == 2'h3
    |-> o_trap_pc == $past(tvec_q)) else $error("machine handler");
  AST_DPC: assert property (o_trap_valid && o_trap_level != 2'h3 |->
    o_trap_pc == $past(i_deleg_tvec)) else $error("delegated handler");
  AST_ONEHOT: assert property (o_trap_valid |->
    o_cause_we == (4'h1 << o_trap_level) && o_ie_clear == o_cause_we)
    else $error("target strobes");
  AST_PRIOR: assert property (s_take |=> o_trap_valid &&
    o_prior_priv == $past(i_priv) && o_prior_ie == $past(i_ie[i_priv]))
    else $error("prior state");
  AST_TAKE: assert property (i_boundary && o_irq_pending |=>
    o_trap_interrupt) else $error("interrupt not taken");
  AST_EXC: assert property (i_exc_valid &&
    !(i_boundary && o_irq_pending) |=> !o_trap_interrupt &&
    o_trap_cause == $past(i_exc_cause)) else $error("exception cause");
  AST_PEND: assert property (s_rd(12'h344) |=>
    o_csr_rdata[11:7] == {$past(i_ext_pending[3:1]), 1'b0,
    $past(i_machine_timer_pending)} &&
    o_csr_rdata[3] == $past(i_machine_soft_pending)) else $error("pending");
endmodule
`default_nettype wire

// file: irq_src_model.sv
// interrupt controller, timer compare and soft register model
`timescale 1ns/1ps
`default_nettype none
module irq_src_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_ext_src,
  input wire logic i_cmp_hit,
  input wire logic i_cmp_wr,
  input wire logic i_soft_wr,
  input wire logic i_soft_val,
  output logic [3:0] o_ext_q,
  output logic o_soft_q,
  output logic o_timer_q
);
  // levels are registered, as a real controller would drive them
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ext_q <= 4'h0;
      o_soft_q <= 1'b0;
      o_timer_q <= 1'b0;
    end else begin
      o_ext_q <= i_ext_src;
      if (i_soft_wr)
        o_soft_q <= i_soft_val;
      if (i_cmp_wr)
        o_timer_q <= 1'b0;
      else if (i_cmp_hit)
        o_timer_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: tb_trap_ctrl.sv
// self-checking bench for the trap unit
`timescale 1ns/1ps
`default_nettype none
module tb_trap_ctrl;
  logic i_clk = 1'b0;
  logic i_sys_rst, i_csr_re, i_csr_we, i_boundary, i_exc_valid;
  logic cmp_hit, cmp_wr, soft_wr, soft_val;
  logic [11:0] i_csr_addr;
  logic [31:0] i_csr_wdata, i_pc, i_deleg_tvec, tvec, v;
  logic [1:0] i_priv;
  logic [3:0] i_ie, ext_src, i_ext_pending;
  logic [4:0] i_exc_cause, c;
  logic i_machine_soft_pending, i_machine_timer_pending;
  logic o_csr_illegal, o_trap_valid, o_trap_interrupt, o_irq_pending;
  logic o_csr_ack;
  logic [31:0] o_csr_rdata, o_trap_epc, o_trap_pc;
  logic [4:0] o_trap_cause;
  logic [1:0] o_trap_level;
  logic [3:0] o_cause_we;
  logic [11:0] ra [5] = '{12'h305, 12'h302, 12'h303, 12'h304, 12'h344};
  int errors = 0;
  int cmp_count = 0;
  always #10 i_clk = ~i_clk;
  trap_ctrl trap_ctrl_inst (
    .i_clk, .i_sys_rst, .i_csr_re, .i_csr_we, .i_csr_addr, .i_csr_wdata,
    .o_csr_ack, .o_csr_illegal, .o_csr_rdata, .i_priv, .i_ie,
    .i_ext_pending, .i_machine_soft_pending, .i_machine_timer_pending,
    .i_boundary, .i_exc_valid, .i_exc_cause, .i_pc, .i_deleg_tvec,
    .o_trap_valid, .o_trap_interrupt, .o_trap_cause, .o_trap_level,
    .o_trap_epc, .o_trap_pc, .o_prior_priv(), .o_prior_ie(), .o_cause_we,
    .o_ie_clear(), .o_irq_pending
  );
  irq_src_model irq_src_model_inst (
    .i_clk, .i_sys_rst, .i_ext_src(ext_src), .i_cmp_hit(cmp_hit),
    .i_cmp_wr(cmp_wr), .i_soft_wr(soft_wr), .i_soft_val(soft_val),
    .o_ext_q(i_ext_pending), .o_soft_q(i_machine_soft_pending),
    .o_timer_q(i_machine_timer_pending)
  );
  // expected handler level for a user exception under a mask
  function automatic logic [1:0] lvl(input logic [31:0] d,
                                     input logic [4:0] k);
    lvl = d[k] ? 2'h2 : 2'h3;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, s, e);
    end
  endtask
  // one register access; answer stands in the cycle after the edge
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(negedge i_clk);
    i_csr_re = ~w;
    i_csr_we = w;
    i_csr_addr = a;
    i_csr_wdata = d;
    @(negedge i_clk);
    i_csr_re = 1'b0;
    i_csr_we = 1'b0;
    chk(o_csr_ack, 1'b1);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h00000000);
    chk(o_csr_rdata, e);
  endtask
  // boundary for one cycle, optionally with an exception
  task automatic trap(input logic x, input logic [4:0] ec, input logic i,
                      input logic [4:0] ek, input logic [1:0] l);
    @(negedge i_clk);
    i_exc_valid = x;
    i_exc_cause = ec;
    i_boundary = 1'b1;
    i_pc = $urandom;
    i_deleg_tvec = $urandom & 32'hFFFFFFFC;
    @(negedge i_clk);
    i_exc_valid = 1'b0;
    i_boundary = 1'b0;
    chk(o_trap_valid, 1'b1);
    chk(o_trap_interrupt, i);
    chk(o_trap_cause, ek);
    chk(o_trap_level, l);
    chk(o_trap_epc, i_pc);
    chk(o_trap_pc, l == 2'h3 ? tvec : i_deleg_tvec);
    chk(o_cause_we, 4'h1 << l);
  endtask
  task automatic end_of_test;
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
  initial begin
    {i_csr_re, i_csr_we, i_boundary, i_exc_valid, cmp_hit, cmp_wr} = '0;
    {soft_wr, soft_val, i_ie, ext_src, i_exc_cause, i_csr_addr} = '0;
    {i_csr_wdata, i_pc, i_deleg_tvec, tvec} = '0;
    i_sys_rst = 1'b1;
    i_priv = 2'h3;
    v = $urandom(81801);
    repeat (5) @(negedge i_clk);
    i_sys_rst = 1'b0;
    foreach (ra[k]) rdchk(ra[k], 32'h00000000);
    // random bases, low bits must drop
    repeat (6) begin
      v = $urandom;
      tvec = v & 32'hFFFFFFFC;
      acc(1'b1, 12'h305, v);
      rdchk(12'h305, tvec);
    end
    // all-ones discovery of writable bits
    for (int k = 1; k < 5; k++) acc(1'b1, ra[k], 32'hFFFFFFFF);
    rdchk(12'h302, 32'hFFFFFFFF);
    rdchk(12'h303, 32'h00000666);
    rdchk(12'h304, 32'h00000EEE);
    rdchk(12'h344, 32'h00000066);
    rdchk(12'h244, 32'h00000066);
    i_priv = 2'h0;
    acc(1'b1, 12'h344, 32'h00000000);
    chk(o_csr_illegal, 1'b1);
    i_priv = 2'h3;
    rdchk(12'h344, 32'h00000066);
    acc(1'b0, 12'h7C0, 32'h00000000);
    chk(o_csr_illegal, 1'b1);
    acc(1'b1, 12'h303, 32'h00000000);
    rdchk(12'h244, 32'h00000000);
    ext_src = 4'hE;
    acc(1'b1, 12'h344, 32'h00000000);
    rdchk(12'h344, 32'h00000E00);
    // all three machine sources at once, removed one by one
    acc(1'b1, 12'h304, 32'h00000888);
    ext_src = 4'h8;
    cmp_hit = 1'b1;
    soft_wr = 1'b1;
    soft_val = 1'b1;
    @(negedge i_clk);
    {cmp_hit, soft_wr, i_ie} = '0;
    acc(1'b1, 12'h344, 32'h00000000);
    rdchk(12'h344, 32'h00000888);
    chk(o_irq_pending, 1'b0);
    i_ie = 4'h8;
    #1 chk(o_irq_pending, 1'b1);
    trap(1'b1, 5'h02, 1'b1, 5'h0B, 2'h3);
    ext_src = 4'h0;
    trap(1'b1, 5'h02, 1'b1, 5'h03, 2'h3);
    soft_wr = 1'b1;
    soft_val = 1'b0;
    trap(1'b1, 5'h02, 1'b1, 5'h07, 2'h3);
    cmp_wr = 1'b1;
    trap(1'b1, 5'h02, 1'b0, 5'h02, 2'h3);
    {cmp_wr, soft_wr} = '0;
    // delegated supervisor timer, handled at hypervisor level
    acc(1'b1, 12'h303, 32'h00000020);
    acc(1'b1, 12'h344, 32'h00000020);
    acc(1'b1, 12'h304, 32'h00000020);
    i_priv = 2'h2;
    i_ie = 4'h4;
    trap(1'b0, 5'h00, 1'b1, 5'h05, 2'h2);
    i_ie = 4'h0;
    #1 chk(o_irq_pending, 1'b0);
    i_priv = 2'h1;
    #1 chk(o_irq_pending, 1'b1);
    i_priv = 2'h3;
    acc(1'b1, 12'h344, 32'h00000000);
    // user exceptions against fixed and random delegation masks
    v = 32'h00000100;
    c = 5'h08;
    repeat (8) begin
      i_priv = 2'h3;
      acc(1'b1, 12'h302, v);
      i_priv = 2'h0;
      i_ie = 4'h1;
      trap(1'b1, c, 1'b0, c, lvl(v, c));
      v = $urandom;
      c = 5'($urandom_range(15));
    end
    end_of_test;
  end
endmodule
bind trap_ctrl trap_ctrl_sva trap_ctrl_sva_inst (
  .i_clk, .i_sys_rst, .i_csr_re, .i_csr_we, .i_csr_addr, .i_csr_wdata,
  .o_csr_rdata, .i_priv, .i_ie, .i_ext_pending, .i_machine_soft_pending,
  .i_machine_timer_pending, .i_boundary, .i_exc_valid, .i_exc_cause,
  .i_deleg_tvec, .o_trap_valid, .o_trap_interrupt, .o_trap_cause,
  .o_trap_level, .o_trap_pc, .o_prior_priv, .o_prior_ie, .o_cause_we,
  .o_ie_clear, .o_irq_pending
);
`default_nettype wire
